// ===== verilog/dma_pkg.sv
// Constants and types for the five-channel DMA controller
package dma_pkg;
    localparam int NCH = 5;
    localparam int NREQ = 64;
    localparam int CH_LSB = 5;
    localparam int SLV_LSB = 28;
    localparam int SLV_W = 4;
    // Register offsets within a channel
    localparam logic [4:0] OFF_CSR = 5'h00;
    localparam logic [4:0] OFF_TRIG = 5'h04;
    localparam logic [4:0] OFF_CNT = 5'h08;
    localparam logic [4:0] OFF_SRC = 5'h0C;
    localparam logic [4:0] OFF_DST = 5'h10;
    // Control and status field positions
    localparam int CSR_EN = 0;
    localparam int CSR_MODE = 1;
    localparam int CSR_WID = 2;
    localparam int CSR_SINC = 4;
    localparam int CSR_DINC = 5;
    localparam int CSR_DONE = 6;
    localparam int CSR_ERR = 7;
    localparam int CSR_BUSY = 8;
    // Trigger and counter field positions
    localparam int TRIG_KIND = 0;
    localparam int TRIG_SOFT = 1;
    localparam int TRIG_SRC = 2;
    localparam int CNT_BLK = 16;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    // Beat widths
    localparam logic [1:0] W8 = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        RD = 2'b01,
        WR = 2'b10,
        GAP = 2'b11
    } st_t;
endpackage : dma_pkg

// ===== verilog/mtx_if.sv
`timescale 1ns/1ps
// Arbitration bundle between the DMA engine and the matrix arbiter
interface mtx_if;
    logic cpu_req;
    logic [dma_pkg::SLV_W-1:0] cpu_slave;
    logic dma_req;
    logic [dma_pkg::SLV_W-1:0] dma_slave;
    logic [dma_pkg::SLV_W-1:0] lock_a;
    logic [dma_pkg::SLV_W-1:0] lock_b;
    logic lock;
    logic cpu_gnt;
    logic dma_gnt;
    modport eng (output cpu_req, cpu_slave, dma_req, dma_slave, lock_a, lock_b, lock,
                 input cpu_gnt, dma_gnt);
    modport arb (input cpu_req, cpu_slave, dma_req, dma_slave, lock_a, lock_b, lock,
                 output cpu_gnt, dma_gnt);
endinterface : mtx_if

// ===== verilog/dma_matrix.sv
`timescale 1ns/1ps
// Bus matrix arbiter between CPU and DMA master
module dma_matrix (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Arbitration bundle
    mtx_if.arb mp
);
    logic held;
    logic same;

    assign held = mp.lock && (mp.cpu_slave == mp.lock_a || mp.cpu_slave == mp.lock_b);
    assign same = mp.cpu_slave == mp.dma_slave;
    assign mp.cpu_gnt = mp.cpu_req && !held;
    assign mp.dma_gnt = mp.dma_req && !(mp.cpu_gnt && same);

    cpu_first_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mp.cpu_req && mp.dma_req && same && !mp.lock |-> mp.cpu_gnt && !mp.dma_gnt)
        else $error("DMA won a clash with the CPU");
    both_go_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mp.cpu_req && mp.dma_req && !same && !held |-> mp.cpu_gnt && mp.dma_gnt)
        else $error("disjoint accesses not both granted");
endmodule : dma_matrix

// ===== verilog/dma_ctrl.sv
`timescale 1ns/1ps
// Five-channel DMA engine with register port and bus master
module dma_ctrl (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Register port
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    // Peripheral request lines
    input logic [dma_pkg::NREQ-1:0] dma_req_lines,
    // CPU side of the matrix
    input logic cpu_req,
    input logic [31:0] cpu_addr,
    output logic cpu_gnt,
    // DMA master bus
    output logic bus_valid,
    output logic [31:0] bus_addr,
    output logic bus_write,
    output logic [1:0] bus_size,
    output logic [31:0] bus_wdata,
    input logic [31:0] bus_rdata,
    input logic bus_ready,
    input logic bus_err,
    // Channel flags
    output logic [dma_pkg::NCH-1:0] chan_done,
    output logic [dma_pkg::NCH-1:0] chan_err
);
    localparam int N = dma_pkg::NCH;
    localparam int SH = dma_pkg::SLV_LSB;
    localparam int SW = dma_pkg::SLV_W;

    dma_pkg::st_t st_q;
    logic [2:0] cur_q;
    logic [2:0] pick;
    logic [N-1:0] rdy;
    logic [N-1:0] en_q;
    logic [N-1:0] kind_q;
    logic [N-1:0] run_q;
    logic [N-1:0] pend_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] done_q;
    logic [N-1:0] err_q;
    logic [N-1:0] software_start_q;
    logic [N-1:0] preemption_mode_select_q;
    logic [N-1:0] source_increment_mode_q;
    logic [N-1:0] destination_increment_mode_q;
    logic [1:0] wid_q [N];
    logic [5:0] hsel_q [N];
    logic [15:0] block_count_q [N];
    logic [7:0] blk_q [N];
    logic [31:0] src_q [N];
    logic [31:0] dst_q [N];
    logic [31:0] data_q;
    logic [31:0] step;
    logic [31:0] rdmux;
    logic [2:0] rch;
    logic [4:0] roff;
    logic own_q;
    logic own_drop;
    logic fin;
    logic beat_done;
    logic last;
    logic blk_start;
    logic active;

    // Places a beat in every lane it may use
    function automatic logic [31:0] fit(input logic [31:0] d, input logic [1:0] w);
        logic [31:0] r;
        r = d;
        if (w == dma_pkg::W8) begin
            r = {4{d[7:0]}};
        end else if (w == dma_pkg::W16) begin
            r = {2{d[15:0]}};
        end
        return r;
    endfunction : fit

    // Register address split
    assign rch = reg_addr[7:dma_pkg::CH_LSB];
    assign roff = reg_addr[dma_pkg::CH_LSB-1:0];

    // Beat bookkeeping
    assign active = st_q == dma_pkg::RD || st_q == dma_pkg::WR;
    assign fin = active && bus_valid && bus_ready;
    assign beat_done = st_q == dma_pkg::WR && fin && !bus_err;
    assign last = block_count_q[cur_q] <= 16'h0001;
    assign blk_start = st_q == dma_pkg::IDLE && rdy != '0;
    // Hold ends with the beat that closes a block or the run
    assign own_drop = fin
        && (bus_err || (bus_write && (last || preemption_mode_select_q[cur_q])));
    assign step = 32'h0000_0001 << wid_q[cur_q];

    always_comb begin
        pick = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (rdy[i]) begin
                pick = 3'(i);
            end
        end
    end

    // Matrix hookup
    mtx_if mx ();
    assign mx.cpu_req = cpu_req;
    assign mx.cpu_slave = cpu_addr[SH +: SW];
    assign mx.dma_req = active;
    assign mx.dma_slave = bus_addr[SH +: SW];
    assign mx.lock_a = src_q[cur_q][SH +: SW];
    assign mx.lock_b = dst_q[cur_q][SH +: SW];
    assign mx.lock = own_q;
    assign cpu_gnt = mx.cpu_gnt;

    dma_matrix u_matrix (
        .core_clk(core_clk),
        .rst(rst),
        .mp(mx)
    );

    // Master bus drive
    assign bus_valid = mx.dma_gnt;
    assign bus_write = st_q == dma_pkg::WR;
    assign bus_addr = bus_write ? dst_q[cur_q] : src_q[cur_q];
    assign bus_size = wid_q[cur_q];
    assign bus_wdata = data_q;
    assign chan_done = done_q;
    assign chan_err = err_q;

    // Transfer sequencer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= dma_pkg::IDLE;
            cur_q <= 3'h0;
        end else begin
            unique case (st_q)
                dma_pkg::IDLE: begin
                    if (blk_start) begin
                        cur_q <= pick;
                        st_q <= dma_pkg::RD;
                    end
                end
                dma_pkg::RD: begin
                    if (fin) begin
                        st_q <= bus_err ? dma_pkg::IDLE : dma_pkg::WR;
                    end
                end
                dma_pkg::WR: begin
                    if (fin) begin
                        if (bus_err || last) begin
                            st_q <= dma_pkg::IDLE;
                        end else if (preemption_mode_select_q[cur_q]) begin
                            st_q <= dma_pkg::GAP;
                        end else begin
                            st_q <= dma_pkg::RD;
                        end
                    end
                end
                dma_pkg::GAP: begin
                    st_q <= dma_pkg::IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || st_q == dma_pkg::IDLE || st_q == dma_pkg::GAP || own_drop) begin
            own_q <= 1'b0;
        end else if (mx.dma_gnt) begin
            own_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_q <= dma_pkg::RST_WORD;
        end else if (st_q == dma_pkg::RD && fin) begin
            data_q <= fit(bus_rdata >> {src_q[cur_q][1:0], 3'b000}, wid_q[cur_q]);
        end
    end

    // Register read mux
    always_comb begin
        rdmux = dma_pkg::RST_WORD;
        if (rch < 3'(N)) begin
            case (roff)
                dma_pkg::OFF_CSR: begin
                    rdmux[dma_pkg::CSR_EN] = en_q[rch];
                    rdmux[dma_pkg::CSR_MODE] = preemption_mode_select_q[rch];
                    rdmux[dma_pkg::CSR_WID +: 2] = wid_q[rch];
                    rdmux[dma_pkg::CSR_SINC] = source_increment_mode_q[rch];
                    rdmux[dma_pkg::CSR_DINC] = destination_increment_mode_q[rch];
                    rdmux[dma_pkg::CSR_DONE] = done_q[rch];
                    rdmux[dma_pkg::CSR_ERR] = err_q[rch];
                    rdmux[dma_pkg::CSR_BUSY] = run_q[rch];
                end
                dma_pkg::OFF_TRIG: begin
                    rdmux[dma_pkg::TRIG_KIND] = kind_q[rch];
                    rdmux[dma_pkg::TRIG_SOFT] = software_start_q[rch];
                    rdmux[dma_pkg::TRIG_SRC +: 6] = hsel_q[rch];
                end
                dma_pkg::OFF_CNT: begin
                    rdmux[15:0] = block_count_q[rch];
                    rdmux[dma_pkg::CNT_BLK +: 8] = blk_q[rch];
                end
                dma_pkg::OFF_SRC: rdmux = src_q[rch];
                dma_pkg::OFF_DST: rdmux = dst_q[rch];
                default: rdmux = dma_pkg::RST_WORD;
            endcase
        end
    end

    // Read data valid for one cycle
    always_ff @(posedge core_clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= dma_pkg::RST_WORD;
        end else begin
            reg_rdata <= rdmux;
        end
    end

    // Per-channel state
    for (genvar c = 0; c < N; c++) begin : g_ch
        logic me;
        logic wr_csr;
        logic wr_trig;
        logic wr_cnt;
        logic req_sel;
        logic hw_hit;
        logic sw_hit;
        logic ok_end;
        logic bad_end;
        assign me = cur_q == 3'(c);
        assign wr_csr = reg_wr && rch == 3'(c) && roff == dma_pkg::OFF_CSR;
        assign wr_trig = reg_wr && rch == 3'(c) && roff == dma_pkg::OFF_TRIG;
        assign wr_cnt = reg_wr && rch == 3'(c) && roff == dma_pkg::OFF_CNT;
        assign req_sel = dma_req_lines[hsel_q[c]];
        assign hw_hit = en_q[c] && kind_q[c] && req_sel && !prev_q[c];
        assign sw_hit = wr_trig && en_q[c] && !reg_wdata[dma_pkg::TRIG_KIND]
            && reg_wdata[dma_pkg::TRIG_SOFT];
        assign ok_end = me && beat_done && last;
        assign bad_end = me && fin && bus_err;
        assign rdy[c] = en_q[c] && run_q[c]
            && (!kind_q[c] || !preemption_mode_select_q[c] || pend_q[c]);

        always_ff @(posedge core_clk) begin
            if (rst) begin
                en_q[c] <= 1'b0;
                preemption_mode_select_q[c] <= 1'b0;
                wid_q[c] <= dma_pkg::W8;
                source_increment_mode_q[c] <= 1'b0;
                destination_increment_mode_q[c] <= 1'b0;
                kind_q[c] <= 1'b0;
                hsel_q[c] <= 6'h00;
            end else begin
                if (wr_csr) begin
                    en_q[c] <= reg_wdata[dma_pkg::CSR_EN];
                    preemption_mode_select_q[c] <= reg_wdata[dma_pkg::CSR_MODE];
                    wid_q[c] <= reg_wdata[dma_pkg::CSR_WID +: 2];
                    source_increment_mode_q[c] <= reg_wdata[dma_pkg::CSR_SINC];
                    destination_increment_mode_q[c] <= reg_wdata[dma_pkg::CSR_DINC];
                end
                if (wr_trig) begin
                    kind_q[c] <= reg_wdata[dma_pkg::TRIG_KIND];
                    hsel_q[c] <= reg_wdata[dma_pkg::TRIG_SRC +: 6];
                end
            end
        end

        // pointers and counts kept per channel
        always_ff @(posedge core_clk) begin
            if (rst) begin
                block_count_q[c] <= dma_pkg::RST_CNT;
                blk_q[c] <= 8'h00;
                src_q[c] <= dma_pkg::RST_WORD;
                dst_q[c] <= dma_pkg::RST_WORD;
            end else begin
                if (wr_cnt) begin
                    block_count_q[c] <= reg_wdata[15:0];
                    blk_q[c] <= reg_wdata[dma_pkg::CNT_BLK +: 8];
                end
                if (reg_wr && rch == 3'(c) && roff == dma_pkg::OFF_SRC) begin
                    src_q[c] <= reg_wdata;
                end
                if (reg_wr && rch == 3'(c) && roff == dma_pkg::OFF_DST) begin
                    dst_q[c] <= reg_wdata;
                end
                if (me && beat_done) begin
                    block_count_q[c] <= block_count_q[c] - 16'h0001;
                    if (source_increment_mode_q[c]) begin
                        src_q[c] <= src_q[c] + step;
                    end
                    if (destination_increment_mode_q[c]) begin
                        dst_q[c] <= dst_q[c] + step;
                    end
                end
                if (ok_end || bad_end) begin
                    blk_q[c] <= 8'h00;
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                run_q[c] <= 1'b0;
                software_start_q[c] <= 1'b0;
                pend_q[c] <= 1'b0;
                prev_q[c] <= 1'b0;
                done_q[c] <= 1'b0;
                err_q[c] <= 1'b0;
            end else begin
                prev_q[c] <= req_sel;
                if (ok_end || bad_end) begin
                    run_q[c] <= 1'b0;
                    software_start_q[c] <= 1'b0;
                end
                if (blk_start && pick == 3'(c)) begin
                    pend_q[c] <= 1'b0;
                end
                if (wr_trig) begin
                    software_start_q[c] <= sw_hit;
                end
                if (wr_csr && reg_wdata[dma_pkg::CSR_DONE]) begin
                    done_q[c] <= 1'b0;
                end
                if (wr_csr && reg_wdata[dma_pkg::CSR_ERR]) begin
                    err_q[c] <= 1'b0;
                end
                if (ok_end) begin
                    done_q[c] <= 1'b1;
                end
                if (bad_end) begin
                    err_q[c] <= 1'b1;
                end
                if (hw_hit) begin
                    pend_q[c] <= 1'b1;
                    run_q[c] <= 1'b1;
                end
                if (sw_hit) begin
                    run_q[c] <= 1'b1;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence gap_s;
        st_q == dma_pkg::GAP && !own_q ##1 st_q == dma_pkg::IDLE;
    endsequence

    prio_pick_a: assert property (
        blk_start |=> ($past(rdy) & ((5'h01 << cur_q) - 5'h01)) == 5'h00)
        else $error("lower ready channel skipped");
    cnt_dec_a: assert property (
        beat_done && !last |=> block_count_q[cur_q] == $past(block_count_q[cur_q]) - 16'h0001)
        else $error("block count did not drop by one");
    src_step_a: assert property (
        beat_done && !last && source_increment_mode_q[cur_q]
        |=> src_q[cur_q] == $past(src_q[cur_q]) + $past(step))
        else $error("source pointer step wrong");
    end_clear_a: assert property (
        beat_done && last |=> st_q == dma_pkg::IDLE && !software_start_q[cur_q]
        && blk_q[cur_q] == 8'h00 && done_q[cur_q] && !run_q[cur_q])
        else $error("completion did not clear start");
    block_gap_a: assert property (
        beat_done && !last && preemption_mode_select_q[cur_q] |=> gap_s)
        else $error("no gap after block");
    bulk_hold_a: assert property (
        beat_done && !last && !preemption_mode_select_q[cur_q] |=> st_q == dma_pkg::RD && own_q)
        else $error("bulk transfer let go");
    off_quiet_a: assert property (
        blk_start |=> en_q[cur_q] && run_q[cur_q])
        else $error("disabled channel started");
endmodule : dma_ctrl

// ===== sim/dma_mem_model.sv
`timescale 1ns/1ps
// Memory and peripheral slave model on the DMA master bus
module dma_mem_model #(
    parameter logic [31:0] PAT = 32'hA5A5_5A5A
) (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Master bus
    input logic bus_valid,
    input logic [31:0] bus_addr,
    output logic [31:0] bus_rdata,
    output logic bus_ready,
    output logic bus_err,
    // Scenario controls
    input logic [1:0] wait_n,
    input logic [31:0] err_addr
);
    logic [1:0] cnt_q;
    logic [31:0] last_q;
    // Beat completes after the chosen number of wait cycles
    assign bus_ready = bus_valid && (cnt_q == wait_n);
    // Read data only with ready, never a stale copy otherwise
    assign bus_rdata = bus_ready ? (bus_addr ^ PAT) : ~last_q;
    assign bus_err = bus_ready && (bus_addr == err_addr);
    // Wait counter restarts on every new or withdrawn beat
    always_ff @(posedge core_clk) begin
        if (rst || !bus_valid || bus_ready) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // Last data handed out
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_q <= 32'h0000_0000;
        end else if (bus_ready) begin
            last_q <= bus_rdata;
        end
    end
endmodule : dma_mem_model

// ===== sim/tb_dma_ctrl.sv
`timescale 1ns/1ps
// Self-checking testbench for the five-channel DMA engine
module tb_dma_ctrl;
    localparam logic [31:0] PAT = 32'hA5A5_5A5A;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata, bus_addr, bus_wdata, bus_rdata, v;
    logic [dma_pkg::NREQ-1:0] dma_req_lines = '0;
    logic cpu_req = 1'h0;
    logic [31:0] cpu_addr = 32'h0000_0000;
    logic cpu_gnt, bus_valid, bus_write, bus_ready, bus_err;
    logic [1:0] bus_size;
    logic [1:0] wait_n = 2'h0;
    logic [31:0] err_addr = 32'hFFFF_FFFF;
    logic [dma_pkg::NCH-1:0] chan_done, chan_err;
    logic [34:0] beats[$];
    logic [31:0] wdq[$];
    int num_errors = 0;
    int tests_run = 0;
    int lost = 0;
    int i, g;

    dma_ctrl i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req_lines(dma_req_lines),
        .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_gnt(cpu_gnt), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_write(bus_write), .bus_size(bus_size), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_err(bus_err),
        .chan_done(chan_done), .chan_err(chan_err));
    dma_mem_model #(.PAT(PAT)) i_mem (.core_clk(core_clk), .rst(rst), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_err(bus_err),
        .wait_n(wait_n), .err_addr(err_addr));

    // Clock
    always #12.5 core_clk = ~core_clk;
    // Beat log and CPU starvation watch on a foreign slave
    always @(posedge core_clk) begin
        if (bus_valid === 1'h1 && bus_ready === 1'h1) begin
            beats.push_back({bus_write, bus_size, bus_addr});
            if (bus_write) wdq.push_back(bus_wdata);
        end
        if (cpu_req && cpu_addr[31:28] == 4'h3 && cpu_gnt !== 1'h1) lost++;
    end

    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input int ch, input logic [4:0] off, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= {ch[2:0], off};
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input int ch, input logic [4:0] off, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= {ch[2:0], off};
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask : rd
    // Configure everything, enable last
    task automatic setup(input int ch, input logic [31:0] csr, trig, input int n);
        wr(ch, dma_pkg::OFF_CSR, csr);
        wr(ch, dma_pkg::OFF_TRIG, trig);
        wr(ch, dma_pkg::OFF_CNT, {8'h00, 8'h01, n[15:0]});
        wr(ch, dma_pkg::OFF_SRC, 32'h1000_0000 + 32'(ch) * 32'h100);
        wr(ch, dma_pkg::OFF_DST, 32'h2000_0000 + 32'(ch) * 32'h100);
        wr(ch, dma_pkg::OFF_CSR, csr | 32'h1);
    endtask : setup
    task automatic wait_flag(input int ch);
        logic [4:0] f;
        f = chan_done | chan_err;
        for (i = 0; i < 2000 && f[ch] !== 1'h1; i++) begin
            @(posedge core_clk);
            f = chan_done | chan_err;
        end
        if (i == 2000) begin
            num_errors++;
            end_sim();
        end
    endtask : wait_flag
    task automatic xfer(input int ch, input logic [1:0] w, input logic si, di, md, input int n);
        logic [31:0] s, d, st;
        s = 32'h1000_0000 + 32'(ch) * 32'h100;
        d = 32'h2000_0000 + 32'(ch) * 32'h100;
        st = 32'h1 << w;
        beats.delete();
        wdq.delete();
        setup(ch, {26'h0, di, si, w, md, 1'h0}, 32'h0, n);
        wr(ch, dma_pkg::OFF_TRIG, 32'h2);
        wait_flag(ch);
        chk(beats.size(), 2 * n);
        for (int k = 0; k < n; k++) begin
            chk(beats[2 * k], {1'h0, w, s + (si ? st * k : 0)});
            chk(beats[2 * k + 1], {1'h1, w, d + (di ? st * k : 0)});
        end
        if (w == 2'h2) chk(wdq[0], s ^ PAT);
        rd(ch, dma_pkg::OFF_TRIG, v);
        chk(v[1], 1'h0);
        rd(ch, dma_pkg::OFF_CNT, v);
        chk(v[23:16], 8'h00);
        wr(ch, dma_pkg::OFF_CSR, 32'hC0);
    endtask : xfer
    task automatic pulse(input int ln);
        @(posedge core_clk);
        dma_req_lines[ln] <= 1'h1;
        repeat (2) @(posedge core_clk);
        dma_req_lines[ln] <= 1'h0;
        repeat (20) @(posedge core_clk);
    endtask : pulse
    task automatic hold(input logic md, input int n);
        beats.delete();
        wait_n <= 2'h2;
        setup(0, {30'h0, md, 1'h0}, 32'h0, n);
        wr(0, dma_pkg::OFF_TRIG, 32'h2);
        for (i = 0; i < 50 && bus_valid !== 1'h1; i++) @(posedge core_clk);
        if (i == 50) begin
            num_errors++;
            end_sim();
        end
        cpu_req <= 1'h1;
        cpu_addr <= 32'h1000_0000;
        g = 0;
        repeat (40) begin
            @(posedge core_clk);
            // Only grants while the channel still runs count
            if (cpu_gnt === 1'h1 && chan_done[0] !== 1'h1) g++;
        end
        chk(g > 0, md);
        cpu_req <= 1'h0;
        wait_flag(0);
        chk(beats.size(), 2 * n);
        wr(0, dma_pkg::OFF_CSR, 32'hC0);
    endtask : hold

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'h0;
        rd(0, dma_pkg::OFF_CSR, v);
        chk(v, dma_pkg::RST_WORD);
        rd(5, dma_pkg::OFF_SRC, v);
        chk(v, 32'h0);
        for (int w = 0; w < 3; w++) begin
            wait_n <= w[1:0];
            xfer(w, w[1:0], 1'h1, 1'h1, w[0], w + 1);
        end
        xfer(3, 2'h2, 1'h0, 1'h1, 1'h0, 2);
        xfer(4, 2'h1, 1'h1, 1'h0, 1'h1, 1);
        beats.delete();
        wr(1, dma_pkg::OFF_TRIG, 32'h2);
        repeat (10) @(posedge core_clk);
        chk(beats.size(), 0);
        setup(1, 32'hA, 32'h0D, 2);
        beats.delete();
        pulse(4);
        chk(beats.size(), 0);
        pulse(3);
        chk(beats.size(), 2);
        chk(chan_done[1], 1'h0);
        pulse(3);
        wait_flag(1);
        chk(beats.size(), 4);
        hold(1'h0, 4);
        hold(1'h1, 3);
        wait_n <= 2'h0;
        cpu_req <= 1'h1;
        cpu_addr <= 32'h1000_0000;
        beats.delete();
        // Both channels see one request edge together
        setup(2, 32'h0, 32'h15, 1);
        setup(0, 32'h0, 32'h15, 1);
        pulse(5);
        chk(beats.size(), 0);
        chk(cpu_gnt, 1'h1);
        cpu_addr <= 32'h3000_0000;
        wait_flag(2);
        chk(beats[0][31:0], 32'h1000_0000);
        chk(beats[2][31:0], 32'h1000_0200);
        chk(lost, 0);
        cpu_req <= 1'h0;
        wr(2, dma_pkg::OFF_CSR, 32'hC0);
        err_addr <= 32'h2000_0200;
        setup(2, 32'h0, 32'h0, 1);
        wr(2, dma_pkg::OFF_TRIG, 32'h2);
        wait_flag(2);
        chk(chan_err[2], 1'h1);
        end_sim();
    end
endmodule : tb_dma_ctrl
